// ===== design/ufl_uart.sv
// Serial channel: FIFOs, baud divider, flow control, infrared and LIN modes
// Contract
// - Tx FIFO empty and Rx threshold interrupts
// - Line status interrupt on OE, PE, FE, break
// - Timeout, modem, buffer error, LIN break interrupts
// - Channel 0 FIFOs 64 bytes, others 16
// - Status readable anytime with four error flags
// - Plain mode: clock over 16*(divisor+2)
// - Extra divider: clock over (X+1)*(divisor+2)
// - Single divide: clock over (divisor+2)
// - Auto flow: receive only while RTS asserted
// - RTS released when Rx count hits level
// - Auto flow: transmit only while CTS asserted; a LIN break request (FS_LINBRK) is sent regardless of CTS
// - Infrared mode only via function select bit 1
// - Infrared frames are 8N1
// - Infrared is half-duplex only; a LIN break request (FS_LINBRK) still starts while a frame is being received
// - LIN enable bit selects LIN 8N1 mode
// - Character length five to eight bits
// - Even, odd or no parity
// - One, one and half, two stop bits
// - False start bits discarded
//
// Design decisions made here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
module ufl_uart import ufl_pkg::*; #(
  parameter bit CHAN0 = 1'b1
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rdata,
  input wire logic ser_in,
  output logic ser_out,
  input wire logic cts_n,
  output logic rts_n,
  output logic tx_fifo_empty_irq,
  output logic rx_threshold_irq,
  output logic line_status_irq,
  output logic timeout_irq,
  output logic modem_irq,
  output logic buf_err_irq,
  output logic lin_break_irq
);
  localparam logic [6:0] DEPTH = CHAN0 ? 7'(DEPTH_CH0) : 7'(DEPTH_CHN);
  localparam logic [5:0] MASK = 6'(DEPTH - 7'd1);

  typedef struct packed {
    logic [6:0] ier;
    logic [3:0] rxlvl;
    logic [3:0] rtslvl;
    logic [1:0] wls;
    logic nsb;
    logic pen;
    logic epe;
    logic rts_sw;
    logic aurts;
    logic aucts;
    logic [7:0] tor;
    logic [15:0] divisor_value;
    logic [3:0] divx;
    logic divone;
    logic diven;
    logic lin_en;
    logic irda_en;
    logic lin_req;
    logic txov;
    logic modem;
    logic pe;
    logic fe;
    logic bi;
    logic linbrk;
    logic oe;
    logic tout;
    logic [7:0] tocnt;
    logic [16:0] tbph;
    logic [6:0] txc;
    logic [6:0] rxc;
    logic [5:0] txw;
    logic [5:0] txr;
    logic [5:0] rxw;
    logic [5:0] rxr;
    logic [15:0] pre;
    ufl_tx_t txs;
    logic [17:0] txph;
    logic [3:0] txbit;
    logic [7:0] txsh;
    ufl_rx_t rxs;
    logic [16:0] rxph;
    logic [3:0] rxbit;
    logic [7:0] rxsh;
    logic rxpb;
    logic [16:0] irst;
    logic cts_q;
    logic rts_n;
    logic ser_out;
    logic [31:0] rdata;
  } ufl_st_t;

  localparam ufl_st_t ST_RST = '{wls: RST_WLS, tor: RST_TOR, txs: TX_IDLE, rxs: RX_IDLE,
    cts_q: 1'b1, rts_n: 1'b1, ser_out: 1'b1, default: '0};

  function automatic logic [3:0] nbits(input logic [1:0] w);
    return 4'd5 + {2'b00, w};
  endfunction

  function automatic logic par_of(input logic [7:0] d, input logic [1:0] w, input logic ev);
    logic [7:0] m;
    m = 8'hff >> (3'd3 - {1'b0, w});
    return ^(d & m) ^ !ev;
  endfunction

  function automatic logic [5:0] inc(input logic [5:0] p);
    return (p + 6'd1) & MASK;
  endfunction

  ufl_st_t q;
  ufl_st_t nx;
  ufl_mem_if tmi();
  ufl_mem_if rmi();
  logic tick;
  logic li;
  logic fix;
  logic [1:0] wls_e;
  logic pen_e;
  logic [3:0] nb;
  logic [15:0] pmax;
  logic [16:0] nbit;
  logic [16:0] nlast;
  logic [16:0] half;
  logic [17:0] stopl;
  logic [17:0] irw;
  logic txpush;
  logic txgo;
  logic rxpop;
  logic rx_push;

  ////////////////////////////////////////////////////////////////////////////////
  // Baud divider: bit time is always pmax+1 clocks times nbit ticks
  // Single divide uses a one-clock tick so the receiver still samples mid-bit
  assign pmax = (q.diven && q.divone) ? 16'h0 : q.divisor_value + 16'd1;
  assign nbit = !q.diven ? 17'(OVS) :
                (q.divone ? {1'b0, q.divisor_value} + 17'd2 : {13'h0, q.divx} + 17'd1);
  assign tick = q.pre >= pmax;
  assign nlast = nbit - 17'd1;
  assign half = nbit >> 1;
  assign fix = q.lin_en || q.irda_en;
  assign wls_e = fix ? 2'h3 : q.wls;
  assign pen_e = !fix && q.pen;
  assign nb = nbits(wls_e);
  assign stopl = (!fix && q.nsb) ? (wls_e == 2'h0 ? {1'b0, nbit} + {1'b0, half} : {nbit, 1'b0})
                                 : {1'b0, nbit};
  assign irw = ({1'b0, nbit} * 18'(IR_NUM)) >> IR_SH;
  // Infrared decoder stretches a short low pulse over the whole bit
  assign li = q.irda_en ? (ser_in && q.irst == 17'h0) : ser_in;

  assign txpush = wr_en && addr == OFF_DATA && q.txc < DEPTH;
  assign rxpop = rd_en && addr == OFF_DATA && q.rxc != 7'h0;
  assign txgo = q.txs == TX_IDLE && !q.lin_req && q.txc != 7'h0 && (!q.aucts || !q.cts_q)
                && !(q.irda_en && q.rxs != RX_IDLE);

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [31:0] w1c;
    logic [31:0] st;
    logic bitv;
    logic brk;
    w1c = (wr_en && addr == OFF_STATUS) ? wdata : 32'h0;
    st = 32'h0;
    bitv = 1'b1;
    brk = 1'b0;
    rx_push = 1'b0;
    nx = q;
    // Clears first so a set in the same cycle wins
    nx.txov = q.txov && !w1c[ST_TXOV];
    nx.modem = q.modem && !w1c[ST_MOD];
    nx.pe = q.pe && !w1c[ST_PE];
    nx.fe = q.fe && !w1c[ST_FE];
    nx.bi = q.bi && !w1c[ST_BI];
    nx.linbrk = q.linbrk && !w1c[ST_LIN];
    nx.oe = q.oe && !w1c[ST_OE];
    if (wr_en) begin
      case (addr)
        OFF_IRQ_EN: nx.ier = wdata[6:0];
        OFF_FIFO_CONTROL: begin
          nx.rxlvl = wdata[FC_RXLVL +: 4];
          nx.rtslvl = wdata[FC_RTSLVL +: 4];
        end
        OFF_LINE_CTL: begin
          nx.wls = wdata[LC_WLS +: 2];
          nx.nsb = wdata[LC_NSB];
          nx.pen = wdata[LC_PEN];
          nx.epe = wdata[LC_EPE];
        end
        OFF_MODEM_CTL: begin
          nx.rts_sw = wdata[MC_RTS];
          nx.aurts = wdata[MC_AURTS];
          nx.aucts = wdata[MC_AUCTS];
        end
        OFF_TIMEOUT: nx.tor = wdata[7:0];
        OFF_BAUD_DIVIDER: begin
          nx.divisor_value = wdata[15:0];
          nx.divx = wdata[BD_DIVX +: 4];
          nx.divone = wdata[BD_ONE];
          nx.diven = wdata[BD_EN];
        end
        OFF_FUNCTION_SELECT: begin
          nx.lin_en = wdata[FS_LIN];
          nx.irda_en = wdata[FS_IRDA];
          if (wdata[FS_LINBRK]) begin
            nx.lin_req = 1'b1;
          end
        end
        default: ;
      endcase
    end
    if (wr_en && addr == OFF_DATA && q.txc >= DEPTH) begin
      nx.txov = 1'b1;
    end
    nx.pre = tick ? 16'h0 : q.pre + 16'd1;

    // Transmitter
    if (txgo) begin
      nx.txs = TX_START;
      nx.txph = 18'h0;
      nx.txsh = tmi.rdata;
    end else if (q.txs == TX_IDLE && q.lin_req) begin
      nx.txs = TX_BRK;
      nx.lin_req = wr_en && addr == OFF_FUNCTION_SELECT && wdata[FS_LINBRK];
      nx.txph = 18'h0;
      nx.txbit = 4'h0;
    end else if (tick && q.txs != TX_IDLE) begin
      nx.txph = q.txph + 18'd1;
      if (q.txs == TX_STOP) begin
        if (q.txph == stopl - 18'd1) begin
          nx.txs = TX_IDLE;
        end
      end else if (q.txph == {1'b0, nlast}) begin
        nx.txph = 18'h0;
        case (q.txs)
          TX_START: begin
            nx.txs = TX_DATA;
            nx.txbit = 4'h0;
          end
          TX_DATA: begin
            if (q.txbit == nb - 4'd1) begin
              nx.txs = pen_e ? TX_PAR : TX_STOP;
            end else begin
              nx.txbit = q.txbit + 4'd1;
            end
          end
          TX_PAR: nx.txs = TX_STOP;
          TX_BRK: begin
            if (q.txbit == 4'(LIN_BRK_BITS - 1)) begin
              nx.txs = TX_STOP;
            end else begin
              nx.txbit = q.txbit + 4'd1;
            end
          end
          default: nx.txs = TX_IDLE;
        endcase
      end
    end
    case (nx.txs)
      TX_START: bitv = 1'b0;
      TX_DATA: bitv = nx.txsh[nx.txbit[2:0]];
      TX_PAR: bitv = par_of(nx.txsh, wls_e, q.epe);
      TX_BRK: bitv = 1'b0;
      default: bitv = 1'b1;
    endcase
    // Infrared encoder sends a low pulse of 3/16 bit for each zero
    nx.ser_out = q.irda_en ? !(!bitv && nx.txph < irw) : bitv;

    // Receiver
    nx.irst = !ser_in ? nbit : ((tick && q.irst != 17'h0) ? q.irst - 17'd1 : q.irst);
    if (q.rxs == RX_IDLE) begin
      if (tick && !li && !(q.aurts && q.rts_n)
          && !(q.irda_en && (q.txs != TX_IDLE || txgo))) begin
        nx.rxs = RX_START;
        nx.rxph = 17'h0;
        nx.rxsh = 8'h0;
      end
    end else if (tick) begin
      nx.rxph = q.rxph == nlast ? 17'h0 : q.rxph + 17'd1;
      case (q.rxs)
        RX_START: begin
          if (q.rxph == half && li) begin
            nx.rxs = RX_IDLE;
          end else if (q.rxph == nlast) begin
            nx.rxs = RX_DATA;
            nx.rxbit = 4'h0;
          end
        end
        RX_DATA: begin
          if (q.rxph == half) begin
            nx.rxsh[q.rxbit[2:0]] = li;
          end
          if (q.rxph == nlast) begin
            if (q.rxbit == nb - 4'd1) begin
              nx.rxs = pen_e ? RX_PAR : RX_STOP;
            end else begin
              nx.rxbit = q.rxbit + 4'd1;
            end
          end
        end
        RX_PAR: begin
          if (q.rxph == half) begin
            nx.rxpb = li;
          end
          if (q.rxph == nlast) begin
            nx.rxs = RX_STOP;
          end
        end
        RX_STOP: begin
          if (q.rxph == half) begin
            nx.rxs = RX_IDLE;
            brk = q.rxsh == 8'h0 && !li && (!pen_e || !q.rxpb);
            if (!li) begin
              nx.fe = 1'b1;
            end
            if (pen_e && q.rxpb != par_of(q.rxsh, wls_e, q.epe)) begin
              nx.pe = 1'b1;
            end
            if (brk) begin
              nx.bi = 1'b1;
            end
            if (brk && q.lin_en) begin
              nx.linbrk = 1'b1;
            end
            if (q.rxc < DEPTH) begin
              rx_push = 1'b1;
            end else begin
              nx.oe = 1'b1;
            end
          end
        end
        default: nx.rxs = RX_IDLE;
      endcase
    end

    // FIFO pointers and counts
    if (txpush) begin
      nx.txw = inc(q.txw);
    end
    if (txgo) begin
      nx.txr = inc(q.txr);
    end
    nx.txc = q.txc + {6'h0, txpush} - {6'h0, txgo};
    if (rx_push) begin
      nx.rxw = inc(q.rxw);
    end
    if (rxpop) begin
      nx.rxr = inc(q.rxr);
    end
    nx.rxc = q.rxc + {6'h0, rx_push} - {6'h0, rxpop};
    if (wr_en && addr == OFF_FIFO_CONTROL && wdata[FC_TXRST]) begin
      nx.txw = 6'h0;
      nx.txr = 6'h0;
      nx.txc = 7'h0;
    end
    if (wr_en && addr == OFF_FIFO_CONTROL && wdata[FC_RXRST]) begin
      nx.rxw = 6'h0;
      nx.rxr = 6'h0;
      nx.rxc = 7'h0;
    end

    // Receive timeout counted in bit times of line silence
    nx.tbph = tick ? (q.tbph >= nlast ? 17'h0 : q.tbph + 17'd1) : q.tbph;
    if (q.rxs != RX_IDLE || q.rxc == 7'h0 || rxpop) begin
      nx.tocnt = 8'h0;
      nx.tout = 1'b0;
    end else if (tick && q.tbph >= nlast && !q.tout) begin
      if (q.tocnt == q.tor) begin
        nx.tout = 1'b1;
      end else begin
        nx.tocnt = q.tocnt + 8'd1;
      end
    end

    // Flow control lines
    nx.cts_q = cts_n;
    if (q.cts_q != cts_n) begin
      nx.modem = 1'b1;
    end
    nx.rts_n = q.aurts ? (q.rxc >= {3'h0, q.rtslvl}) : !q.rts_sw;

    // Register read, data stands one cycle
    st[ST_TXOV] = q.txov;
    st[ST_MOD] = q.modem;
    st[ST_PE] = q.pe;
    st[ST_FE] = q.fe;
    st[ST_BI] = q.bi;
    st[ST_LIN] = q.linbrk;
    st[ST_OE] = q.oe;
    st[ST_TOUT] = q.tout;
    st[ST_RXE] = q.rxc == 7'h0;
    st[ST_RXF] = q.rxc >= DEPTH;
    st[ST_TXE] = q.txc == 7'h0;
    st[ST_TXF] = q.txc >= DEPTH;
    st[ST_TXI] = q.txs == TX_IDLE;
    nx.rdata = 32'h0;
    if (rd_en) begin
      case (addr)
        OFF_DATA: nx.rdata = {24'h0, rmi.rdata};
        OFF_IRQ_EN: nx.rdata = {25'h0, q.ier};
        OFF_FIFO_CONTROL: nx.rdata = {12'h0, q.rtslvl, 8'h0, q.rxlvl, 4'h0};
        OFF_LINE_CTL: nx.rdata = {27'h0, q.epe, q.pen, q.nsb, q.wls};
        OFF_MODEM_CTL: nx.rdata = {26'h0, q.aucts, q.aurts, 3'h0, q.rts_sw};
        OFF_STATUS: nx.rdata = st;
        OFF_TIMEOUT: nx.rdata = {24'h0, q.tor};
        OFF_BAUD_DIVIDER: nx.rdata = {2'h0, q.diven, q.divone, q.divx, 8'h0, q.divisor_value};
        OFF_FUNCTION_SELECT: nx.rdata = {30'h0, q.irda_en, q.lin_en};
        OFF_COUNT: nx.rdata = {17'h0, q.txc, 1'b0, q.rxc};
        default: nx.rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      q <= ST_RST;
    end else if (ce) begin
      q <= nx;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // FIFO storage; read address runs one cycle ahead (next pointer) so head data is ready
  assign tmi.en = ce;
  assign tmi.we = txpush;
  assign tmi.waddr = q.txw;
  assign tmi.wdata = wdata[7:0];
  assign tmi.raddr = nx.txr;
  assign rmi.en = ce;
  assign rmi.we = rx_push;
  assign rmi.waddr = q.rxw;
  assign rmi.wdata = q.rxsh;
  assign rmi.raddr = nx.rxr;
  ufl_mem u_txm (.clk(clk), .m(tmi.mem));
  ufl_mem u_rxm (.clk(clk), .m(rmi.mem));

  assign rdata = q.rdata;
  assign ser_out = q.ser_out;
  assign rts_n = q.rts_n;
  assign tx_fifo_empty_irq = q.txc == 7'h0 && q.ier[IE_TXE];
  assign rx_threshold_irq = q.rxc > {3'h0, q.rxlvl} && q.ier[IE_RXTH];
  assign line_status_irq = (q.pe || q.fe || q.bi || q.oe) && q.ier[IE_LS];
  assign timeout_irq = q.tout && q.ier[IE_TOUT];
  assign modem_irq = q.modem && q.ier[IE_MOD];
  assign buf_err_irq = q.txov && q.ier[IE_BUF];
  assign lin_break_irq = q.linbrk && q.ier[IE_LIN];

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_txe;
    ce && txpush |=> !tx_fifo_empty_irq;
  endproperty
  a_txe: assert property (p_txe) else $error("tx empty irq after push");
  property p_ls;
    ce && q.rxs == RX_STOP && tick && q.rxph == half && !li && q.ier[IE_LS] |=> line_status_irq;
  endproperty
  a_ls: assert property (p_ls) else $error("no line status irq on framing error");
  property p_div0;
    ce && !q.diven && q.pre == q.divisor_value + 16'd1 |=> q.pre == 16'h0;
  endproperty
  a_div0: assert property (p_div0) else $error("plain divider wrong");
  property p_divx;
    ce && q.diven && !q.divone && tick && q.txs == TX_DATA && q.txph == 18'(q.divx) |=> q.txph == 18'h0;
  endproperty
  a_divx: assert property (p_divx) else $error("extra divider bit length wrong");
  property p_one;
    ce && q.diven && q.divone |=> q.pre == 16'h0;
  endproperty
  a_one: assert property (p_one) else $error("single divide tick wrong");
  property p_rxgate;
    q.aurts && q.rts_n && q.rxs == RX_IDLE |=> q.rxs == RX_IDLE;
  endproperty
  a_rxgate: assert property (p_rxgate) else $error("receive while rts released");
  property p_rts;
    ce && q.aurts && q.rxc >= {3'h0, q.rtslvl} |=> rts_n;
  endproperty
  a_rts: assert property (p_rts) else $error("rts not released at level");
  property p_cts;
    q.aucts && q.cts_q && q.txs == TX_IDLE |=> q.txs != TX_START;
  endproperty
  a_cts: assert property (p_cts) else $error("sent without cts");
  property p_hdx;
    q.irda_en && q.txs != TX_IDLE && q.rxs == RX_IDLE |=> q.rxs == RX_IDLE;
  endproperty
  a_hdx: assert property (p_hdx) else $error("infrared full duplex");
  property p_false;
    ce && q.rxs == RX_START && tick && q.rxph == half && li |=> q.rxs == RX_IDLE;
  endproperty
  a_false: assert property (p_false) else $error("false start accepted");
  property p_rst;
    disable iff (1'b0) sys_rst |=> ser_out && rts_n && q.txc == 7'h0 && q.rxc == 7'h0 && !line_status_irq;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  c_tx: cover property (ce && txgo);
  c_rx: cover property (ce && rx_push);
  c_lin: cover property (ce && q.txs == TX_BRK);
  c_fs: cover property (ce && q.rxs == RX_START && tick && q.rxph == half && li);
endmodule

// ===== design/ufl_pkg.sv
// Shared constants and types for the serial channel
package ufl_pkg;
  // Register offsets
  localparam logic [7:0] OFF_DATA = 8'h00;
  localparam logic [7:0] OFF_IRQ_EN = 8'h04;
  localparam logic [7:0] OFF_FIFO_CONTROL = 8'h08;
  localparam logic [7:0] OFF_LINE_CTL = 8'h0c;
  localparam logic [7:0] OFF_MODEM_CTL = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  localparam logic [7:0] OFF_TIMEOUT = 8'h18;
  localparam logic [7:0] OFF_BAUD_DIVIDER = 8'h1c;
  localparam logic [7:0] OFF_FUNCTION_SELECT = 8'h20;
  localparam logic [7:0] OFF_COUNT = 8'h24;
  // Field positions
  localparam int FC_RXRST = 1;
  localparam int FC_TXRST = 2;
  localparam int FC_RXLVL = 4;
  localparam int FC_RTSLVL = 16;
  localparam int LC_WLS = 0;
  localparam int LC_NSB = 2;
  localparam int LC_PEN = 3;
  localparam int LC_EPE = 4;
  localparam int MC_RTS = 0;
  localparam int MC_AURTS = 4;
  localparam int MC_AUCTS = 5;
  localparam int BD_DIVX = 24;
  localparam int BD_ONE = 28;
  localparam int BD_EN = 29;
  localparam int FS_LIN = 0;
  localparam int FS_IRDA = 1;
  localparam int FS_LINBRK = 8;
  localparam int IE_TXE = 0;
  localparam int IE_RXTH = 1;
  localparam int IE_LS = 2;
  localparam int IE_MOD = 3;
  localparam int IE_TOUT = 4;
  localparam int IE_BUF = 5;
  localparam int IE_LIN = 6;
  localparam int ST_TXOV = 0;
  localparam int ST_MOD = 3;
  localparam int ST_PE = 4;
  localparam int ST_FE = 5;
  localparam int ST_BI = 6;
  localparam int ST_LIN = 7;
  localparam int ST_OE = 8;
  localparam int ST_TOUT = 9;
  localparam int ST_RXE = 14;
  localparam int ST_RXF = 15;
  localparam int ST_TXE = 22;
  localparam int ST_TXF = 23;
  localparam int ST_TXI = 24;
  localparam int CN_TX = 8;
  // Reset values
  localparam logic [1:0] RST_WLS = 2'h3;
  localparam logic [7:0] RST_TOR = 8'h40;
  // Timing
  localparam int OVS = 16;
  localparam int LIN_BRK_BITS = 13;
  localparam int IR_NUM = 3;
  localparam int IR_SH = 4;
  localparam int DEPTH_CH0 = 64;
  localparam int DEPTH_CHN = 16;
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP, TX_BRK} ufl_tx_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} ufl_rx_t;
endpackage

// ===== design/ufl_mem_if.sv
// FIFO storage port between channel and memory
`timescale 1ns/1ps
interface ufl_mem_if;
  logic en;
  logic we;
  logic [5:0] waddr;
  logic [5:0] raddr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport ctl(output en, we, waddr, raddr, wdata, input rdata);
  modport mem(input en, we, waddr, raddr, wdata, output rdata);
endinterface

// ===== design/ufl_mem.sv
// Byte memory with registered read data
`timescale 1ns/1ps
module ufl_mem (
  input wire logic clk,
  ufl_mem_if.mem m
);
  logic [7:0] ram [64];
  always_ff @(posedge clk) begin
    if (m.en) begin
      if (m.we) begin
        ram[m.waddr] <= m.wdata;
      end
      // Bypass so a byte written now is seen at once
      m.rdata <= (m.we && m.waddr == m.raddr) ? m.wdata : ram[m.raddr];
    end
  end
endmodule

// ===== bench/ufl_peer.sv
// Line-side partner: serial peer with clear-to-send
`timescale 1ns/1ps
module ufl_peer (
  input wire logic clk,
  input wire logic ser_out,
  output logic ser_in,
  output logic cts_n
);
  int bitc = 5;
  int rx_cnt = 0;
  logic [7:0] rx_byte = 8'h00;
  initial begin
    ser_in = 1'b1;
    cts_n = 1'b1;
  end
  ////////////////////////////////////////////////////////////////
  task automatic set_cts(input logic v);
    @(posedge clk);
    cts_n <= v;
  endtask
  task automatic bit_out(input logic v);
    ser_in <= v;
    repeat (bitc) @(posedge clk);
  endtask
  // Start, LSB first, optional parity, stop; the stop level is free so errors can be made
  // Sends at once without watching ser_out; any infrared turnaround gap is left to software
  task automatic send(input logic [7:0] d, input bit pe, input logic pv, input logic sv);
    @(posedge clk);
    bit_out(1'b0);
    for (int i = 0; i < 8; i++) begin
      bit_out(d[i]);
    end
    if (pe) begin
      bit_out(pv);
    end
    bit_out(sv);
    bit_out(1'b1);
    bit_out(1'b1);
  endtask
  ////////////////////////////////////////////////////////////////
  // Mid-bit sampling, so a wrong divider shows up as a wrong byte
  always begin
    logic [7:0] b;
    @(negedge ser_out);
    repeat (bitc / 2 + bitc) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      b[i] = ser_out;
      repeat (bitc) @(posedge clk);
    end
    rx_byte = b;
    rx_cnt++;
  end
endmodule

// ===== bench/ufl_uart_tb.sv
// Self-checking bench for the serial channel
`timescale 1ns/1ps
module ufl_uart_tb;
  import ufl_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic ser_in, ser_out, cts_n, rts_n, tx_irq, rxth_irq, ls_irq, to_irq, md_irq, be_irq, lb_irq;
  int bad_count = 0;
  int checks = 0;
  logic [31:0] lc [5] = '{32'h1b, 32'h1b, 32'h0b, 32'h03, 32'h03};
  logic [7:0] dat [5] = '{8'h01, 8'h01, 8'h01, 8'h81, 8'h00};
  bit pe [5] = '{1, 1, 1, 0, 0};
  logic pv [5] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
  logic sv [5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
  logic [31:0] msk [5] = '{32'h10, 32'h10, 32'h10, 32'h20, 32'h40};
  logic [31:0] ex [5] = '{32'h10, 32'h0, 32'h0, 32'h20, 32'h40};
  logic [31:0] bd [3] = '{32'h0000_0000, 32'h2800_0003, 32'h3000_0003};
  int bc [3] = '{32, 45, 5};
  int n;
  always #2.5 clk = ~clk;
  ////////////////////////////////////////////////////////////////
  ufl_uart ufl_uart_i (
    .clk(clk), .sys_rst(sys_rst), .ce(1'b1), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .rdata(rdata), .ser_in(ser_in), .ser_out(ser_out), .cts_n(cts_n), .rts_n(rts_n),
    .tx_fifo_empty_irq(tx_irq), .rx_threshold_irq(rxth_irq), .line_status_irq(ls_irq), .timeout_irq(to_irq),
    .modem_irq(md_irq), .buf_err_irq(be_irq), .lin_break_irq(lb_irq)
  );
  ufl_peer ufl_peer_i (.clk(clk), .ser_out(ser_out), .ser_in(ser_in), .cts_n(cts_n));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 chk(rdata & m, e);
  endtask
  task automatic wait_bits(input int k);
    repeat (k * ufl_peer_i.bitc) @(posedge clk);
    #1;
  endtask
  task automatic report_and_stop;
    if (bad_count == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    bad_count++;
    report_and_stop();
  end
  initial begin
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    #1 chk(32'({ser_out, rts_n}), 32'h3);
    rd_chk(OFF_LINE_CTL, 32'h1f, 32'h3);
    rd_chk(OFF_TIMEOUT, 32'hff, 32'h40);
    rd_chk(OFF_STATUS, 32'hffff_ffff, 32'h0140_4000);
    rd_chk(8'hfc, 32'hffff_ffff, 32'h0);
    wr(OFF_IRQ_EN, 32'h07);
    #1 chk(32'({tx_irq, rxth_irq, ls_irq}), 32'h4);
    // One byte per divider mode; the peer's bit period follows the formula
    for (int m = 0; m < 3; m++) begin
      wr(OFF_BAUD_DIVIDER, bd[m]);
      ufl_peer_i.bitc = bc[m];
      wr(OFF_DATA, 32'h60 + 32'(m));
      wait_bits(12);
      chk(32'(ufl_peer_i.rx_byte), 32'h60 + 32'(m));
    end
    ufl_peer_i.send(8'h3c, 0, 1'b0, 1'b1);
    chk(32'(rxth_irq), 32'h1);
    rd_chk(OFF_DATA, 32'hff, 32'h3c);
    chk(32'(rxth_irq), 32'h0);
    for (int i = 0; i < 5; i++) begin
      wr(OFF_LINE_CTL, lc[i]);
      ufl_peer_i.send(dat[i], pe[i], pv[i], sv[i]);
      rd_chk(OFF_STATUS, msk[i], ex[i]);
      chk(32'(ls_irq), 32'(ex[i] != 0));
      wr(OFF_STATUS, 32'h1f0);
      wr(OFF_FIFO_CONTROL, 32'h2);
      #1 chk(32'(ls_irq), 32'h0);
    end
    // Five-bit character: the trailing stop and idle read as ones
    wr(OFF_LINE_CTL, 32'h0);
    wr(OFF_DATA, 32'h0a);
    wait_bits(12);
    chk(32'(ufl_peer_i.rx_byte), 32'hea);
    wr(OFF_LINE_CTL, 32'h3);
    wr(OFF_MODEM_CTL, 32'h20);
    n = ufl_peer_i.rx_cnt;
    wr(OFF_DATA, 32'h5a);
    wait_bits(20);
    chk(32'(ufl_peer_i.rx_cnt), 32'(n));
    ufl_peer_i.set_cts(1'b0);
    wait_bits(12);
    chk(32'(ufl_peer_i.rx_byte), 32'h5a);
    wr(OFF_FIFO_CONTROL, 32'h0002_0002);
    wr(OFF_MODEM_CTL, 32'h10);
    wait_bits(1);
    chk(32'(rts_n), 32'h0);
    ufl_peer_i.send(8'h11, 0, 1'b0, 1'b1);
    ufl_peer_i.send(8'h22, 0, 1'b0, 1'b1);
    chk(32'(rts_n), 32'h1);
    ufl_peer_i.send(8'h33, 0, 1'b0, 1'b1);
    rd_chk(OFF_COUNT, 32'h7f, 32'h2);
    rd_chk(OFF_DATA, 32'hff, 32'h11);
    rd_chk(OFF_DATA, 32'hff, 32'h22);
    wait_bits(1);
    chk(32'(rts_n), 32'h0);
    // LIN break out, then a break in LIN mode; the unread byte then runs into the timeout
    wr(OFF_IRQ_EN, 32'h7f);
    wr(OFF_FUNCTION_SELECT, 32'h101);
    wait_bits(16);
    chk(32'(ufl_peer_i.rx_byte), 32'h0);
    ufl_peer_i.send(8'h00, 0, 1'b0, 1'b0);
    rd_chk(OFF_STATUS, 32'h80, 32'h80);
    chk(32'({lb_irq, md_irq, be_irq}), 32'h6);
    wait_bits(70);
    chk(32'(to_irq), 32'h1);
    report_and_stop();
  end
endmodule
